// ### design/tmu_clk_sel.sv
// Purpose: Counter clock source selection, producing one count tick per source clock.
// Assumes: High and time-base clocks arrive as one-cycle ticks on the system clock.
// Notes:   The external pin is synchronised by two flip-flops before edge detection.
`timescale 1ns/1ps
`default_nettype none
module tmu_clk_sel
  import tmu_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic [2:0] i_sel,
  input  wire logic       i_ext_en,
  input  wire logic       i_high_tick,
  input  wire logic       i_tbc_tick,
  input  wire logic       i_ext_pin,
  output logic            o_tick
);

  logic [1:0] sys_div_q;
  logic [5:0] hi_div_q;
  logic       sync1_q;
  logic       sync2_q;
  logic       sync3_q;
  logic       tick_d;

  // ---------------------------------------------------------------------------
  // Prescalers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      sys_div_q <= 2'h0;
    end else begin
      sys_div_q <= sys_div_q + 2'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      hi_div_q <= 6'h00;
    end else if (i_high_tick) begin
      hi_div_q <= hi_div_q + 6'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // External pin synchroniser
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= i_ext_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Source select
  // ---------------------------------------------------------------------------
  always_comb begin
    case (tmu_cks_e'(i_sel))
      TMU_CK_SYS_DIV4: tick_d = (sys_div_q == TMU_SYS_DIV_LAST);
      TMU_CK_SYS:      tick_d = 1'b1;
      TMU_CK_HI_DIV16: tick_d = i_high_tick && (hi_div_q[3:0] == TMU_HI_DIV16_LAST[3:0]);
      TMU_CK_HI_DIV64: tick_d = i_high_tick && (hi_div_q == TMU_HI_DIV64_LAST);
      TMU_CK_TBC_A:    tick_d = i_tbc_tick;
      TMU_CK_TBC_B:    tick_d = i_tbc_tick;
      TMU_CK_EXT_RISE: tick_d = i_ext_en && sync2_q && !sync3_q;
      TMU_CK_EXT_FALL: tick_d = i_ext_en && !sync2_q && sync3_q;
      default:         tick_d = 1'b0;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= tick_d;
    end
  end

endmodule
`default_nettype wire

// ### design/tmu_timer.sv
// Purpose: Standard timer unit: 10-bit counter, two comparators, output pins, APB registers.
// Assumes: APB slave with one wait state; internal clock ticks come from same-clock logic.
// Notes:   Low bytes of counter and compare A pass through one shared 8-bit holding buffer.
`timescale 1ns/1ps
`default_nettype none
module tmu_timer
  import tmu_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic [31:0]            o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic              i_internal_high_clock,
  input  wire logic              i_time_base_clock,
  input  wire logic              i_timer_ext_clock_in,
  output logic                   o_timer_out_primary,
  output logic                   o_timer_out_inverted,
  output logic [2:0]             o_pin_timer_sel,
  output logic                   o_irq
);

  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("ADDR_W must be at least 8");
  end

  logic [7:0]  ctrl0_q;
  logic [7:0]  ctrl1_q;
  logic [9:0]  cnt_q;
  logic [9:0]  cmpa_q;
  logic [7:0]  hold_q;
  logic [1:0]  sta_q;
  logic [1:0]  msk_q;
  logic [2:0]  pin_q;
  logic        on_prev_q;
  logic        out_q;
  logic        pulse_done_q;
  logic        tick;
  logic        run;
  logic        on_rise;
  logic [9:0]  cnt_inc;
  logic        hit_a;
  logic        hit_p;
  logic        ev_a;
  logic        ev_p;
  logic        clr_cnt;
  logic        wr_fire;
  logic        rd_fire;
  logic        mapped;
  logic        addr_hi_ok;
  logic [7:0]  off;
  logic [31:0] rdata;
  logic [2:0]  rp;
  logic [1:0]  mode;
  logic [1:0]  io;
  logic [1:0]  sta_d;

  assign off     = i_paddr[7:0];
  assign rp      = ctrl0_q[TMU_C0_RP_LSB +: 3];
  assign mode    = ctrl1_q[TMU_C1_MODE_LSB +: 2];
  assign io      = ctrl1_q[TMU_C1_IO_LSB +: 2];
  assign run     = ctrl0_q[TMU_C0_ON] && !ctrl0_q[TMU_C0_PAUSE];
  assign on_rise = ctrl0_q[TMU_C0_ON] && !on_prev_q;
  assign wr_fire = i_psel && i_penable && o_pready && i_pwrite && addr_hi_ok;
  assign rd_fire = i_psel && i_penable && !o_pready && !i_pwrite && addr_hi_ok;

  // Address bits above the register map must be zero; an 8-bit bus has none.
  if (ADDR_W > 8) begin : g_addr_hi
    assign addr_hi_ok = (i_paddr[ADDR_W-1:8] == '0);
  end else begin : g_addr_lo
    assign addr_hi_ok = 1'b1;
  end

  // ---------------------------------------------------------------------------
  // Count clock
  // ---------------------------------------------------------------------------
  tmu_clk_sel u_clk_sel (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_sel       (ctrl0_q[TMU_C0_CKS_LSB +: 3]),
    .i_ext_en    (pin_q[TMU_PIN_CKIN]),
    .i_high_tick (i_internal_high_clock),
    .i_tbc_tick  (i_time_base_clock),
    .i_ext_pin   (i_timer_ext_clock_in),
    .o_tick      (tick)
  );

  // ---------------------------------------------------------------------------
  // Comparators and counter
  // ---------------------------------------------------------------------------
  assign cnt_inc = cnt_q + 10'h001;
  // A period value of zero lets the counter run to its overflow.
  assign hit_p = (rp == 3'h0) ? (cnt_q == TMU_CNT_MAX)
                              : ((cnt_inc[9:7] == rp) && (cnt_inc[6:0] == 7'h00));
  assign hit_a = (cnt_inc == cmpa_q);
  assign ev_p  = run && tick && hit_p;
  assign ev_a  = run && tick && hit_a;
  assign clr_cnt = ctrl1_q[TMU_C1_CCLR] ? hit_a : hit_p;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      on_prev_q <= 1'b0;
    end else begin
      on_prev_q <= ctrl0_q[TMU_C0_ON];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cnt_q <= 10'h000;
    end else if (on_rise) begin
      cnt_q <= 10'h000;
    end else if (run && tick) begin
      if (clr_cnt) begin
        cnt_q <= 10'h000;
      end else begin
        cnt_q <= cnt_inc;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Output pin logic
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      out_q        <= 1'b0;
      pulse_done_q <= 1'b0;
    end else if (on_rise) begin
      out_q        <= ctrl1_q[TMU_C1_OC];
      pulse_done_q <= 1'b0;
    end else begin
      case (tmu_mode_e'(mode))
        TMU_M_COMPARE: begin
          if (ev_a) begin
            case (io)
              2'b01:   out_q <= 1'b0;
              2'b10:   out_q <= 1'b1;
              2'b11:   out_q <= !out_q;
              default: out_q <= out_q;
            endcase
          end
        end
        TMU_M_PWM: begin
          case (io)
            2'b00:   out_q <= !ctrl1_q[TMU_C1_OC];
            2'b01:   out_q <= ctrl1_q[TMU_C1_OC];
            2'b10: begin
              if (ev_a) begin
                out_q <= !ctrl1_q[TMU_C1_OC];
              end else if (run && tick && clr_cnt) begin
                out_q <= ctrl1_q[TMU_C1_OC];
              end
            end
            default: begin
              if (ev_a) begin
                out_q        <= !ctrl1_q[TMU_C1_OC];
                pulse_done_q <= 1'b1;
              end else if (!pulse_done_q && run) begin
                out_q <= ctrl1_q[TMU_C1_OC];
              end
            end
          endcase
        end
        default: out_q <= out_q;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_timer_out_primary  <= 1'b0;
      o_timer_out_inverted <= 1'b0;
      o_pin_timer_sel      <= 3'h0;
    end else begin
      o_timer_out_primary  <= pin_q[TMU_PIN_OUTP] &&
                              (out_q ^ ctrl1_q[TMU_C1_POL]);
      o_timer_out_inverted <= pin_q[TMU_PIN_OUTN] &&
                              !(out_q ^ ctrl1_q[TMU_C1_POL]);
      o_pin_timer_sel      <= pin_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ctrl0_q <= TMU_RST_CTRL;
      ctrl1_q <= TMU_RST_CTRL;
      msk_q   <= 2'h0;
      pin_q   <= 3'h0;
    end else if (wr_fire) begin
      case (off)
        TMU_OFF_CTRL0:   ctrl0_q <= i_pwdata[7:0];
        TMU_OFF_CTRL1:   ctrl1_q <= i_pwdata[7:0];
        TMU_OFF_IRQ_MSK: msk_q   <= i_pwdata[1:0];
        TMU_OFF_PIN_SEL: pin_q   <= i_pwdata[2:0];
        default:         ctrl0_q <= ctrl0_q;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Compare A and holding buffer
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cmpa_q <= 10'h000;
    end else if (wr_fire && (off == TMU_OFF_CMPA_HI)) begin
      cmpa_q <= {i_pwdata[1:0], hold_q};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      hold_q <= 8'h00;
    end else if (wr_fire && (off == TMU_OFF_CMPA_LO)) begin
      hold_q <= i_pwdata[7:0];
    end else if (rd_fire && (off == TMU_OFF_CNT_HI)) begin
      hold_q <= cnt_q[7:0];
    end else if (rd_fire && (off == TMU_OFF_CMPA_HI)) begin
      hold_q <= cmpa_q[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------------
  always_comb begin
    sta_d = sta_q;
    if (wr_fire && (off == TMU_OFF_IRQ_STA)) begin
      sta_d = sta_q & ~i_pwdata[1:0];
    end
    sta_d[TMU_IRQ_A] = sta_d[TMU_IRQ_A] | ev_a;
    sta_d[TMU_IRQ_P] = sta_d[TMU_IRQ_P] | ev_p;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      sta_q <= 2'h0;
      o_irq <= 1'b0;
    end else begin
      sta_q <= sta_d;
      o_irq <= |(sta_d & msk_q);
    end
  end

  // ---------------------------------------------------------------------------
  // APB read path
  // ---------------------------------------------------------------------------
  always_comb begin
    rdata  = 32'h0000_0000;
    mapped = 1'b1;
    case (off)
      TMU_OFF_CTRL0:   rdata[7:0] = ctrl0_q;
      TMU_OFF_CTRL1:   rdata[7:0] = ctrl1_q;
      TMU_OFF_CNT_LO:  rdata[7:0] = hold_q;
      TMU_OFF_CNT_HI:  rdata[1:0] = cnt_q[9:8];
      TMU_OFF_CMPA_LO: rdata[7:0] = hold_q;
      TMU_OFF_CMPA_HI: rdata[1:0] = cmpa_q[9:8];
      TMU_OFF_IRQ_STA: rdata[1:0] = sta_q;
      TMU_OFF_IRQ_MSK: rdata[1:0] = msk_q;
      TMU_OFF_PIN_SEL: rdata[2:0] = pin_q;
      default:         mapped     = 1'b0;
    endcase
    if (!addr_hi_ok) begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_psel && i_penable && !o_pready) begin
      o_pready  <= 1'b1;
      o_prdata  <= i_pwrite ? 32'h0000_0000 : (mapped ? rdata : 32'h0000_0000);
      o_pslverr <= !mapped;
    end else begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### inc/tmu_pkg.sv
// Purpose: Shared constants of the timer unit: register map, field layout and encodings.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Registers hold their data in the low bits; upper bits read as zero.
package tmu_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] TMU_OFF_CTRL0   = 8'h00;
  localparam logic [7:0] TMU_OFF_CTRL1   = 8'h04;
  localparam logic [7:0] TMU_OFF_CNT_LO  = 8'h08;
  localparam logic [7:0] TMU_OFF_CNT_HI  = 8'h0c;
  localparam logic [7:0] TMU_OFF_CMPA_LO = 8'h10;
  localparam logic [7:0] TMU_OFF_CMPA_HI = 8'h14;
  localparam logic [7:0] TMU_OFF_IRQ_STA = 8'h18;
  localparam logic [7:0] TMU_OFF_IRQ_MSK = 8'h1c;
  localparam logic [7:0] TMU_OFF_PIN_SEL = 8'h20;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int TMU_C0_PAUSE   = 7;
  localparam int TMU_C0_CKS_LSB = 4;
  localparam int TMU_C0_ON      = 3;
  localparam int TMU_C0_RP_LSB  = 0;
  localparam int TMU_C1_MODE_LSB = 6;
  localparam int TMU_C1_IO_LSB  = 4;
  localparam int TMU_C1_OC      = 3;
  localparam int TMU_C1_POL     = 2;
  localparam int TMU_C1_CCLR    = 0;
  localparam int TMU_IRQ_A      = 0;
  localparam int TMU_IRQ_P      = 1;
  localparam int TMU_PIN_CKIN   = 0;
  localparam int TMU_PIN_OUTP   = 1;
  localparam int TMU_PIN_OUTN   = 2;

  // ---------------------------------------------------------------------------
  // Reset values and sizes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] TMU_RST_CTRL = 8'h00;
  localparam logic [9:0] TMU_CNT_MAX  = 10'h3ff;
  localparam logic [1:0] TMU_SYS_DIV_LAST = 2'h3;
  localparam logic [5:0] TMU_HI_DIV16_LAST = 6'h0f;
  localparam logic [5:0] TMU_HI_DIV64_LAST = 6'h3f;

  // ---------------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    TMU_CK_SYS_DIV4 = 3'b000,
    TMU_CK_SYS      = 3'b001,
    TMU_CK_HI_DIV16 = 3'b010,
    TMU_CK_HI_DIV64 = 3'b011,
    TMU_CK_TBC_A    = 3'b100,
    TMU_CK_TBC_B    = 3'b101,
    TMU_CK_EXT_RISE = 3'b110,
    TMU_CK_EXT_FALL = 3'b111
  } tmu_cks_e;

  typedef enum logic [1:0] {
    TMU_M_COMPARE = 2'b00,
    TMU_M_UNDEF   = 2'b01,
    TMU_M_PWM     = 2'b10,
    TMU_M_TIMER   = 2'b11
  } tmu_mode_e;

endpackage

// ### tb/test_tmu_timer.sv
// Purpose: Self-checking bench of the timer unit.
// Assumes: One wait state per register access.
// Notes:   Counts are read high byte first, then low byte.
`timescale 1ns/1ps
`default_nettype none
module test_tmu_timer;
  import tmu_pkg::*;
  localparam int HP = 3;
  localparam int TP = 5;
  localparam logic [6:0] LVL = 7'b0101010;
  logic        i_ref_clk, i_reset, i_psel, i_penable, i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic        o_pready, o_pslverr, hi_tick, tb_tick, ext_pin, ext_run;
  logic        o_p, o_n, o_irq, err, pv;
  logic [2:0]  o_sel;
  logic [9:0]  v, got;
  int          n_mismatch, checked, seed, rises, falls, r0, f0, n, k, t, tog;
  logic [7:0]  offs[6] = '{TMU_OFF_CTRL0, TMU_OFF_CTRL1, TMU_OFF_CNT_HI,
                           TMU_OFF_IRQ_STA, TMU_OFF_IRQ_MSK, TMU_OFF_PIN_SEL};
  logic [7:0]  bad[3] = '{8'h24, 8'h02, 8'hfc};
  logic [7:0]  acts[7] = '{8'h19, 8'h21, 8'h25, 8'h09, 8'h88, 8'h98, 8'ha8};
  tmu_timer #(
    .ADDR_W(8)
  ) uut (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_internal_high_clock(hi_tick),
    .i_time_base_clock(tb_tick), .i_timer_ext_clock_in(ext_pin),
    .o_timer_out_primary(o_p), .o_timer_out_inverted(o_n), .o_pin_timer_sel(o_sel),
    .o_irq(o_irq)
  );
  tmu_pin_model #(
    .HI_PER(HP),
    .TB_PER(TP)
  ) u_pins (
    .i_ref_clk(i_ref_clk), .i_ext_run(ext_run), .o_high_tick(hi_tick),
    .o_tbc_tick(tb_tick), .o_ext_pin(ext_pin)
  );
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge ext_pin) rises++;
  always @(negedge ext_pin) falls++;
  // ----------
  // Helpers
  // ----------
  task automatic chk(input string what, input int lo, input int hi, input logic [31:0] seen);
    checked++;
    if ((seen >= lo && seen <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int c;
    c = 0;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {24'h0, d};
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      c++;
    end while (o_pready !== 1'b1 && c < 16);
    if (c >= 16) begin
      n_mismatch++;
      $display("[FAIL] pready expected 1 seen 0");
      close_out();
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd10(input logic [7:0] hi);
    apb(1'b0, hi, 8'h0);
    got[9:8] = rd[1:0];
    apb(1'b0, hi - 8'h04, 8'h0);
    got[7:0] = rd[7:0];
  endtask
  function automatic int ticks(input int s, input int c);
    case (s)
      0: return c / 4;
      1: return c;
      2: return c / (16 * HP);
      3: return c / (64 * HP);
      6: return rises - r0;
      7: return falls - f0;
      8: return 0;
      default: return c / TP;
    endcase
  endfunction
  initial begin
    seed = 32'h07018435;
    {i_reset, i_psel, i_penable, i_pwrite, ext_run} = 5'b10000;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    n_mismatch = 0;
    checked = 0;
    repeat (12) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    @(posedge i_ref_clk);
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 8'h0);
      chk("reset value", 0, 0, rd);
    end
    foreach (bad[i]) begin
      apb(i[0], bad[i], 8'hff);
      chk("slverr", 1, 1, err);
    end
    $display("done registers");
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 10'h3ff : 10'($random(seed));
      wr(TMU_OFF_CMPA_LO, v[7:0]);
      wr(TMU_OFF_CMPA_HI, {6'h0, v[9:8]});
      rd10(TMU_OFF_CMPA_HI);
      chk("compare a", v, v, got);
      wr(TMU_OFF_CMPA_LO, ~v[7:0]);
      rd10(TMU_OFF_CMPA_HI);
      chk("compare a low", v, v, got);
    end
    $display("done buffer");
    wr(TMU_OFF_CTRL1, 8'hc0);
    for (int s = 0; s < 9; s++) begin
      n = 300 + ($random(seed) & 127);
      k = (s == 8) ? 6 : s;
      wr(TMU_OFF_PIN_SEL, {7'h0, s < 8});
      wr(TMU_OFF_CTRL0, 8'h0);
      wr(TMU_OFF_CTRL0, 8'(k * 16 + 8));
      r0 = rises;
      f0 = falls;
      ext_run <= 1'b1;
      repeat (n) @(posedge i_ref_clk);
      ext_run <= 1'b0;
      wr(TMU_OFF_CTRL0, 8'(k * 16 + 136));
      rd10(TMU_OFF_CNT_HI);
      t = ticks(s, n + 3);
      chk("count", (t > 2) ? t - 2 : 0, t + 2, got);
    end
    $display("done clock sources");
    wr(TMU_OFF_CMPA_LO, 8'h5);
    wr(TMU_OFF_CMPA_HI, 8'h0);
    wr(TMU_OFF_PIN_SEL, 8'h6);
    for (int i = 0; i < 8; i++) begin
      wr(TMU_OFF_CTRL0, 8'h0);
      wr(TMU_OFF_CTRL1, (i < 7) ? acts[i] : 8'h31);
      wr(TMU_OFF_CTRL0, 8'h18);
      tog = 0;
      pv = o_p;
      repeat (100) begin
        @(posedge i_ref_clk);
        if (o_p !== pv) tog++;
        pv = o_p;
      end
      if (i < 7) chk("primary", LVL[i], LVL[i], o_p);
      else chk("toggles", 19, 21, tog);
      chk("inverted", 1, 1, o_p ^ o_n);
      chk("pin select", 6, 6, o_sel);
    end
    wr(TMU_OFF_PIN_SEL, 8'h0);
    repeat (3) @(posedge i_ref_clk);
    chk("gated pins", 0, 0, {o_p, o_n});
    $display("done pins");
    v = 10'(1 + ($random(seed) & 63));
    wr(TMU_OFF_CMPA_LO, v[7:0]);
    wr(TMU_OFF_CMPA_HI, 8'h0);
    wr(TMU_OFF_CTRL1, 8'hc0);
    wr(TMU_OFF_CTRL0, 8'h0);
    wr(TMU_OFF_IRQ_STA, 8'h3);
    wr(TMU_OFF_CTRL0, 8'h19);
    repeat (300) @(posedge i_ref_clk);
    wr(TMU_OFF_CTRL0, 8'h11);
    rd10(TMU_OFF_CNT_HI);
    chk("count in period", 0, 127, got);
    apb(1'b0, TMU_OFF_IRQ_STA, 8'h0);
    chk("status", 3, 3, rd);
    chk("masked irq", 0, 0, o_irq);
    for (int i = 0; i < 2; i++) begin
      wr(TMU_OFF_IRQ_MSK, 8'(1 << i));
      repeat (2) @(posedge i_ref_clk);
      chk("irq raised", 1, 1, o_irq);
      wr(TMU_OFF_IRQ_STA, 8'(1 << i));
      apb(1'b0, TMU_OFF_IRQ_STA, 8'h0);
      chk("status cleared", 2 - 2 * i, 2 - 2 * i, rd);
      chk("irq cleared", 0, 0, o_irq);
    end
    $display("done interrupts");
    n = got;
    wr(TMU_OFF_CNT_LO, 8'hff);
    wr(TMU_OFF_CNT_HI, 8'h3);
    rd10(TMU_OFF_CNT_HI);
    chk("count kept", n, n, got);
    wr(TMU_OFF_CTRL0, 8'h98);
    rd10(TMU_OFF_CNT_HI);
    chk("count cleared", 0, 0, got);
    $display("done counter");
    close_out();
  end
endmodule
`default_nettype wire

// ### tb/tmu_pin_model.sv
// Purpose: Far side of the timer: clock ticks and the external count pin.
// Assumes: Ticks are one cycle wide on the system clock.
// Notes:   The count pin toggles off-phase to the clock while enabled.
`timescale 1ns/1ps
`default_nettype none
module tmu_pin_model #(
  parameter int HI_PER = 3,
  parameter int TB_PER = 5
) (
  input  wire logic i_ref_clk,
  input  wire logic i_ext_run,
  output logic      o_high_tick,
  output logic      o_tbc_tick,
  output logic      o_ext_pin
);
  int   hi_cnt  = 0;
  int   tb_cnt  = 0;
  logic pin_lvl = 1'b0;
  assign o_ext_pin = pin_lvl;
  // Internal sources tick at fixed rates.
  always @(posedge i_ref_clk) begin
    hi_cnt <= (hi_cnt + 1) % HI_PER;
    tb_cnt <= (tb_cnt + 1) % TB_PER;
    o_high_tick <= (hi_cnt == 0);
    o_tbc_tick <= (tb_cnt == 0);
  end
  // The pin toggles unrelated to the clock phase.
  always begin
    #61;
    if (i_ext_run) pin_lvl = ~pin_lvl;
  end
endmodule
`default_nettype wire

// ### tb/tmu_timer_monitor.sv
// Purpose: Port checks of the timer unit.
// Assumes: Bound to every tmu_timer instance.
// Notes:   One clock domain, so one default clocking.
`timescale 1ns/1ps
`default_nettype none
module tmu_timer_monitor
  import tmu_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              i_ref_clk,
  input wire logic              i_reset,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0]       i_pwdata,
  input wire logic [31:0]       o_prdata,
  input wire logic              o_pready,
  input wire logic              o_pslverr,
  input wire logic              o_timer_out_primary,
  input wire logic              o_timer_out_inverted,
  input wire logic [2:0]        o_pin_timer_sel,
  input wire logic              o_irq
);
  logic       done_wr;
  logic [1:0] mask_q;
  logic [2:0] sel_q;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  assign done_wr = i_psel && i_penable && o_pready && i_pwrite;
  // ----------
  // Checks
  // ----------
  sequence s_wr(logic [7:0] off);
    done_wr && i_paddr == ADDR_W'(off);
  endsequence
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      mask_q <= 2'h0;
    end else if (done_wr && i_paddr == ADDR_W'(TMU_OFF_IRQ_MSK)) begin
      mask_q <= i_pwdata[1:0];
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (done_wr && i_paddr == ADDR_W'(TMU_OFF_PIN_SEL)) begin
      sel_q <= i_pwdata[2:0];
    end
  end
  a_ready_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("pready late");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready held");
  a_ready_qual: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access");
  a_err_zero: assert property (o_pslverr |-> o_pready && (i_pwrite || o_prdata == 32'h0))
    else $error("bad error answer");
  a_sel_copy: assert property (s_wr(TMU_OFF_PIN_SEL) |-> ##[1:2] o_pin_timer_sel == sel_q)
    else $error("pin select not copied");
  a_pins_inverse: assert property (o_pin_timer_sel[2:1] == 2'b11
    && $past(o_pin_timer_sel[2:1]) == 2'b11 |-> o_timer_out_inverted != o_timer_out_primary)
    else $error("pins not inverse");
  a_gate_primary: assert property (!o_pin_timer_sel[1] && !$past(o_pin_timer_sel[1])
    |-> !o_timer_out_primary)
    else $error("primary pin not gated");
  a_irq_masked: assert property (o_irq |-> $past(mask_q) != 2'h0)
    else $error("irq while masked");
endmodule
bind tmu_timer tmu_timer_monitor #(
  .ADDR_W(ADDR_W)
) u_mon (
  .i_ref_clk(i_ref_clk),
  .i_reset(i_reset),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .i_pwrite(i_pwrite),
  .i_paddr(i_paddr),
  .i_pwdata(i_pwdata),
  .o_prdata(o_prdata),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .o_timer_out_primary(o_timer_out_primary),
  .o_timer_out_inverted(o_timer_out_inverted),
  .o_pin_timer_sel(o_pin_timer_sel),
  .o_irq(o_irq)
);
`default_nettype wire
